// >>> verilog/ddrpi_defines.svh
// Constants of the DDR SDRAM pin interface: widths, bit positions, timing counts.
// Assumes nothing; included by bare name wherever a constant is needed.
`ifndef DDRPI_DEFINES_SVH
`define DDRPI_DEFINES_SVH

`define DDRPI_ADDR_W          15
`define DDRPI_DATA_W          64
`define DDRPI_ECC_W           8
`define DDRPI_LANES           9
`define DDRPI_ECC_LANE        8
`define DDRPI_SHARED_BIT      10
`define DDRPI_KEEP_MASK       15'h0400
`define DDRPI_PER_W           8
`define DDRPI_PER_MAX         8'hFF
`define DDRPI_SYNC_W          91
`define DDRPI_CLK_PERIOD_NS   5
`define DDRPI_RD_TIMEOUT_NS   400
`define DDRPI_RD_TIMEOUT_CYC  ((`DDRPI_RD_TIMEOUT_NS) / (`DDRPI_CLK_PERIOD_NS))

`endif

// >>> verilog/ddrpi_pkg.sv
// Types of the DDR SDRAM pin interface: request, read answer, operations, states.
// Assumes the constants header is on the include path.
`include "ddrpi_defines.svh"

package ddrpi_pkg;

    typedef enum logic [0:0] {
        DDRPI_OP_READ  = 1'b0,
        DDRPI_OP_WRITE = 1'b1
    } ddrpi_op_e;

    typedef enum logic [2:0] {
        DDRPI_S_IDLE = 3'b000,
        DDRPI_S_ROW  = 3'b001,
        DDRPI_S_COL  = 3'b010,
        DDRPI_S_WR   = 3'b011,
        DDRPI_S_RD   = 3'b100
    } ddrpi_state_e;

    typedef struct packed {
        ddrpi_op_e                    op;
        logic [`DDRPI_ADDR_W-1:0]     row;
        logic [`DDRPI_ADDR_W-1:0]     col;
        logic [`DDRPI_DATA_W-1:0]     wdata;
        logic [`DDRPI_ECC_W-1:0]      wecc;
        logic [`DDRPI_LANES-1:0]      byte_en;
    } ddrpi_req_s;

    typedef struct packed {
        logic [`DDRPI_DATA_W-1:0]     data;
        logic [`DDRPI_ECC_W-1:0]      ecc;
    } ddrpi_rd_s;

endpackage : ddrpi_pkg

// >>> verilog/ddrpi_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is sampled independently; bundles are skew-tolerant by design.
`timescale 1ns/10ps

module ddrpi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule : ddrpi_sync

// >>> verilog/ddrpi_lane_capture.sv
// One byte lane of read capture, clocked by clk_i and sampling on rising edges of the received (synchronised) strobes.
// Assumes strobe and data inputs already passed the synchroniser together.
`timescale 1ns/10ps

module ddrpi_lane_capture (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       arm_i,
    input  wire logic       x4_i,
    input  wire logic       strobe_lo_i,
    input  wire logic       strobe_hi_i,
    input  wire logic [7:0] dq_i,
    output logic      [7:0] byte_o,
    output logic            done_o
);

    logic lo_prev_reg;
    logic hi_prev_reg;
    logic lo_got_reg;
    logic hi_got_reg;
    logic lo_rise;
    logic hi_rise;

    // On x4 modules the upper nibble has its own strobe on the mask pin.
    assign lo_rise = strobe_lo_i & ~lo_prev_reg;
    assign hi_rise = x4_i ? (strobe_hi_i & ~hi_prev_reg) : lo_rise;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lo_prev_reg <= 1'b0;
            hi_prev_reg <= 1'b0;
            lo_got_reg  <= 1'b0;
            hi_got_reg  <= 1'b0;
            byte_o      <= 8'h00;
            done_o      <= 1'b0;
        end else begin
            lo_prev_reg <= strobe_lo_i;
            hi_prev_reg <= strobe_hi_i;
            if (arm_i) begin
                lo_got_reg <= 1'b0;
                hi_got_reg <= 1'b0;
                done_o     <= 1'b0;
            end else begin
                if (lo_rise && !lo_got_reg) begin
                    byte_o[3:0] <= dq_i[3:0];
                    lo_got_reg  <= 1'b1;
                end
                if (hi_rise && !hi_got_reg) begin
                    byte_o[7:4] <= dq_i[7:4];
                    hi_got_reg  <= 1'b1;
                end
                done_o <= (lo_got_reg | lo_rise) & (hi_got_reg | hi_rise);
            end
        end
    end

endmodule : ddrpi_lane_capture

// >>> verilog/ddrpi_pin_if.sv
// Pin-level DDR SDRAM interface: address copies, clock enables, data and check-bit lanes.
// Assumes the forwarded memory clock comes back as a pin input slower than clk_i/4,
// and that request fields are stable from the same clock domain.
//
// How it works
// - Normally the second address bus is the inverse of the first, except bit ten.
// - During memory initialisation both address buses carry identical values.
// - Two separate fifteen-bit multiplexed address buses share the address load.
// - Address buses change a quarter link cycle after the forwarded clock rises.
// - Both clock-enable outputs always carry the same value.
// - Clock enables are low while reset is asserted.
// - Clock enables stay low through self refresh and return high afterwards.
// - Clock enables change at the same quarter-cycle launch point as addresses.
// - Device drives the data bus on writes, memory drives it on reads.
// - Write strobes, one per byte lane, rise in the middle of each data beat.
// - Read data is captured with the strobes the memory sends, edge aligned.
// - On x4 modules mask pins act as extra nibble strobes both directions.
// - The data bus floats whenever nobody drives it.
// - Eight check bits cover the data bytes, driven on writes, sampled on reads.
// - The check-bit lane uses the same strobe scheme as the data bytes.
// - The check-bit bus floats whenever nobody drives it.
// - On x4 modules partial writes become read-modify-write with all bytes enabled.
// - x4 accesses use eighteen strobes: nine strobe pins plus nine mask pins.
`timescale 1ns/10ps
`include "ddrpi_defines.svh"

module ddrpi_pin_if (
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      init_phase_i,
    input  wire logic                      self_refresh_i,
    input  wire logic                      x4_mode_i,
    input  wire logic                      req_valid_i,
    input  wire ddrpi_pkg::ddrpi_req_s     req_i,
    output logic                           req_ready_o,
    output logic                           rd_valid_o,
    output ddrpi_pkg::ddrpi_rd_s           rd_o,
    output logic                           rd_timeout_o,
    input  wire logic                      forwarded_mem_clock_i,
    output logic [`DDRPI_ADDR_W-1:0]       mem_addr_primary_o,
    output logic [`DDRPI_ADDR_W-1:0]       mem_addr_inverted_copy_o,
    output logic                           mem_clock_enable_a_o,
    output logic                           mem_clock_enable_b_o,
    input  wire logic [`DDRPI_DATA_W-1:0]  mem_data_bus_i,
    output logic [`DDRPI_DATA_W-1:0]       mem_data_bus_o,
    output logic                           mem_data_bus_oe_o,
    input  wire logic [`DDRPI_ECC_W-1:0]   mem_check_bits_i,
    output logic [`DDRPI_ECC_W-1:0]        mem_check_bits_o,
    output logic                           mem_check_bits_oe_o,
    input  wire logic [`DDRPI_LANES-1:0]   mem_strobe_i,
    output logic [`DDRPI_LANES-1:0]        mem_strobe_o,
    output logic                           mem_strobe_oe_o,
    input  wire logic [`DDRPI_LANES-1:0]   mem_mask_i,
    output logic [`DDRPI_LANES-1:0]        mem_mask_o,
    output logic                           mem_mask_oe_o
);

    // ==========================================================================
    // Shared decode
    // ==========================================================================
    function automatic logic [`DDRPI_ADDR_W-1:0] ddrpi_copy_of(
        input logic [`DDRPI_ADDR_W-1:0] v,
        input logic                     init
    );
        // Inverting halves simultaneous switching; bit ten keeps polarity.
        ddrpi_copy_of = init ? v : (~v ^ `DDRPI_KEEP_MASK);
    endfunction : ddrpi_copy_of

    // ==========================================================================
    // Pin synchronisers
    // ==========================================================================
    logic [`DDRPI_SYNC_W-1:0] sync_q;
    logic                     fclk_s;
    logic [`DDRPI_LANES-1:0]  strobe_s;
    logic [`DDRPI_LANES-1:0]  mask_s;
    logic [`DDRPI_DATA_W-1:0] data_s;
    logic [`DDRPI_ECC_W-1:0]  ecc_s;
    ddrpi_sync #(
        .W (`DDRPI_SYNC_W)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      ({forwarded_mem_clock_i, mem_strobe_i, mem_mask_i, mem_data_bus_i, mem_check_bits_i}),
        .q_o      (sync_q)
    );

    assign {fclk_s, strobe_s, mask_s, data_s, ecc_s} = sync_q;

    // ==========================================================================
    // Forwarded clock phase tracking
    // ==========================================================================
    logic                    fclk_prev_reg;
    logic [`DDRPI_PER_W-1:0] phase_reg;
    logic [`DDRPI_PER_W-1:0] period_reg;
    logic [`DDRPI_PER_W-1:0] quarter;
    logic [`DDRPI_PER_W-1:0] mid;
    logic                    fclk_rise;
    logic                    launch;
    logic                    center;
    assign fclk_rise = fclk_s & ~fclk_prev_reg;
    assign quarter   = period_reg >> 2;
    assign mid       = quarter + (period_reg >> 1);
    // The period is re-measured every cycle of the forwarded clock, so a change
    // of memory clock rate is followed after one link cycle.
    assign launch    = (phase_reg == quarter);
    assign center    = (phase_reg == mid);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fclk_prev_reg <= 1'b0;
            phase_reg     <= '0;
            period_reg    <= '0;
        end else begin
            fclk_prev_reg <= fclk_s;
            if (fclk_rise) begin
                phase_reg  <= '0;
                period_reg <= phase_reg + 8'h01;
            end else if (phase_reg != `DDRPI_PER_MAX) begin
                phase_reg  <= phase_reg + 8'h01;
            end
        end
    end

    // ==========================================================================
    // Request sequencing
    // ==========================================================================
    ddrpi_pkg::ddrpi_state_e  state_reg;
    ddrpi_pkg::ddrpi_req_s    hold_reg;
    logic                     x4_reg;
    logic                     rmw_reg;
    logic                     wr_started_reg;
    logic                     arm_reg;
    logic [`DDRPI_PER_W-1:0]  wait_reg;
    logic [`DDRPI_LANES-1:0]  lane_done;
    logic [7:0]               lane_byte [`DDRPI_LANES];
    logic [`DDRPI_DATA_W-1:0] cap_data;
    logic [`DDRPI_ECC_W-1:0]  cap_ecc;
    logic [`DDRPI_DATA_W-1:0] merged_data;
    logic [`DDRPI_ECC_W-1:0]  merged_ecc;
    logic                     accept;
    assign accept = req_valid_i & req_ready_o;
    genvar gl;
    generate
        for (gl = 0; gl < `DDRPI_LANES; gl++) begin : g_lane
            ddrpi_lane_capture u_cap (
                .clk_i       (clk_i),
                .resetn_i    (resetn_i),
                .arm_i       (arm_reg),
                .x4_i        (x4_reg),
                .strobe_lo_i (strobe_s[gl]),
                .strobe_hi_i (mask_s[gl]),
                .dq_i        ((gl == `DDRPI_ECC_LANE) ? ecc_s : data_s[8*(gl%8) +: 8]),
                .byte_o      (lane_byte[gl]),
                .done_o      (lane_done[gl])
            );
            if (gl == `DDRPI_ECC_LANE) begin : g_ecc
                assign cap_ecc    = lane_byte[gl];
                assign merged_ecc = hold_reg.byte_en[gl] ? hold_reg.wecc : lane_byte[gl];
            end else begin : g_dat
                assign cap_data[8*gl +: 8]    = lane_byte[gl];
                assign merged_data[8*gl +: 8] = hold_reg.byte_en[gl] ? hold_reg.wdata[8*gl +: 8] : lane_byte[gl];
            end
        end
    endgenerate

    // Without byte masks an x4 partial write first reads the line, merges, then
    // writes every byte; a full write goes straight through.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg    <= ddrpi_pkg::DDRPI_S_IDLE;
            hold_reg     <= '0;
            x4_reg       <= 1'b0;
            rmw_reg      <= 1'b0;
            arm_reg      <= 1'b0;
            wait_reg     <= '0;
            req_ready_o  <= 1'b0;
            rd_valid_o   <= 1'b0;
            rd_o         <= '0;
            rd_timeout_o <= 1'b0;
        end else begin
            arm_reg      <= 1'b0;
            rd_valid_o   <= 1'b0;
            rd_timeout_o <= 1'b0;
            unique case (state_reg)
                ddrpi_pkg::DDRPI_S_IDLE: begin
                    req_ready_o <= ~accept;
                    if (accept) begin
                        hold_reg  <= req_i;
                        x4_reg    <= x4_mode_i;
                        rmw_reg   <= x4_mode_i && (req_i.op == ddrpi_pkg::DDRPI_OP_WRITE)
                                     && !(&req_i.byte_en);
                        if (x4_mode_i && !(&req_i.byte_en)) begin
                            hold_reg.op <= ddrpi_pkg::DDRPI_OP_READ;
                        end
                        state_reg <= ddrpi_pkg::DDRPI_S_ROW;
                    end
                end
                ddrpi_pkg::DDRPI_S_ROW: begin
                    if (launch) begin
                        state_reg <= ddrpi_pkg::DDRPI_S_COL;
                    end
                end
                ddrpi_pkg::DDRPI_S_COL: begin
                    if (launch) begin
                        wait_reg <= '0;
                        if (hold_reg.op == ddrpi_pkg::DDRPI_OP_WRITE) begin
                            state_reg <= ddrpi_pkg::DDRPI_S_WR;
                        end else begin
                            arm_reg   <= 1'b1;
                            state_reg <= ddrpi_pkg::DDRPI_S_RD;
                        end
                    end
                end
                ddrpi_pkg::DDRPI_S_WR: begin
                    if (launch && wr_started_reg) begin
                        state_reg   <= ddrpi_pkg::DDRPI_S_IDLE;
                        req_ready_o <= 1'b1;
                    end
                end
                ddrpi_pkg::DDRPI_S_RD: begin
                    if (!arm_reg && (&lane_done)) begin
                        if (rmw_reg) begin
                            hold_reg.wdata   <= merged_data;
                            hold_reg.wecc    <= merged_ecc;
                            hold_reg.byte_en <= '1;
                            hold_reg.op      <= ddrpi_pkg::DDRPI_OP_WRITE;
                            rmw_reg          <= 1'b0;
                            state_reg        <= ddrpi_pkg::DDRPI_S_COL;
                        end else begin
                            rd_valid_o  <= 1'b1;
                            rd_o.data   <= cap_data;
                            rd_o.ecc    <= cap_ecc;
                            state_reg   <= ddrpi_pkg::DDRPI_S_IDLE;
                            req_ready_o <= 1'b1;
                        end
                    end else if (wait_reg == 8'(`DDRPI_RD_TIMEOUT_CYC)) begin
                        // A missing strobe must not hang the interface.
                        rd_timeout_o <= 1'b1;
                        rmw_reg      <= 1'b0;
                        state_reg    <= ddrpi_pkg::DDRPI_S_IDLE;
                        req_ready_o  <= 1'b1;
                    end else begin
                        wait_reg <= wait_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg   <= ddrpi_pkg::DDRPI_S_IDLE;
                    req_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================================
    // Address buses and clock enables
    // ==========================================================================

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_addr_primary_o       <= '0;
            mem_addr_inverted_copy_o <= '0;
        end else if (launch) begin
            if (state_reg == ddrpi_pkg::DDRPI_S_ROW) begin
                mem_addr_primary_o       <= hold_reg.row;
                mem_addr_inverted_copy_o <= ddrpi_copy_of(hold_reg.row, init_phase_i);
            end else if (state_reg == ddrpi_pkg::DDRPI_S_COL) begin
                mem_addr_primary_o       <= hold_reg.col;
                mem_addr_inverted_copy_o <= ddrpi_copy_of(hold_reg.col, init_phase_i);
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_clock_enable_a_o <= 1'b0;
            mem_clock_enable_b_o <= 1'b0;
        end else if (launch) begin
            mem_clock_enable_a_o <= ~self_refresh_i;
            mem_clock_enable_b_o <= ~self_refresh_i;
        end
    end

    // ==========================================================================
    // Write data, check bits and strobes
    // ==========================================================================

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_started_reg      <= 1'b0;
            mem_data_bus_o      <= '0;
            mem_data_bus_oe_o   <= 1'b0;
            mem_check_bits_o    <= '0;
            mem_check_bits_oe_o <= 1'b0;
            mem_strobe_o        <= '0;
            mem_strobe_oe_o     <= 1'b0;
            mem_mask_o          <= '0;
            mem_mask_oe_o       <= 1'b0;
        end else if ((state_reg == ddrpi_pkg::DDRPI_S_WR) && launch) begin
            if (!wr_started_reg) begin
                wr_started_reg      <= 1'b1;
                mem_data_bus_o      <= hold_reg.wdata;
                mem_data_bus_oe_o   <= 1'b1;
                mem_check_bits_o    <= hold_reg.wecc;
                mem_check_bits_oe_o <= 1'b1;
                mem_strobe_o        <= '0;
                mem_strobe_oe_o     <= 1'b1;
                mem_mask_o          <= x4_reg ? '0 : ~hold_reg.byte_en;
                mem_mask_oe_o       <= 1'b1;
            end else begin
                // End of the beat: release every lane so the bus floats.
                wr_started_reg      <= 1'b0;
                mem_data_bus_oe_o   <= 1'b0;
                mem_check_bits_oe_o <= 1'b0;
                mem_strobe_o        <= '0;
                mem_strobe_oe_o     <= 1'b0;
                mem_mask_o          <= '0;
                mem_mask_oe_o       <= 1'b0;
            end
        end else if (wr_started_reg && center) begin
            mem_strobe_o <= '1;
            if (x4_reg) begin
                mem_mask_o <= '1;
            end
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_drive_start;
        $rose(mem_data_bus_oe_o) && (mem_strobe_o == '0);
    endsequence
    sequence s_center_rise;
        $rose(mem_strobe_o[0]) && mem_data_bus_oe_o && $past(center);
    endsequence

    chk_inv_copy: assert property ($past(launch) && !$past(init_phase_i) && $changed(mem_addr_primary_o)
        |-> mem_addr_inverted_copy_o == (~mem_addr_primary_o ^ `DDRPI_KEEP_MASK))
        else $error("inverted address copy wrong");
    chk_init_copy: assert property ($past(launch) && $past(init_phase_i) && $changed(mem_addr_primary_o)
        |-> mem_addr_inverted_copy_o == mem_addr_primary_o)
        else $error("address copy inverted during initialisation");
    chk_addr_launch: assert property ($changed(mem_addr_primary_o) |-> $past(launch))
        else $error("address changed off the launch point");
    chk_row_then_col: assert property (state_reg == ddrpi_pkg::DDRPI_S_ROW && launch
        |=> mem_addr_primary_o == hold_reg.row ##[1:300] mem_addr_primary_o == hold_reg.col)
        else $error("row then column order broken");
    chk_cke_pair: assert property (mem_clock_enable_a_o == mem_clock_enable_b_o)
        else $error("clock enables differ");
    chk_cke_selfref: assert property (launch && self_refresh_i |=> !mem_clock_enable_a_o)
        else $error("clock enable high in self refresh");
    chk_cke_launch: assert property ($changed(mem_clock_enable_a_o) |-> $past(launch))
        else $error("clock enable changed off the launch point");
    chk_strobe_center: assert property (s_drive_start |-> ##[1:300] s_center_rise)
        else $error("write strobe not centred in the beat");
    chk_data_release: assert property (state_reg != ddrpi_pkg::DDRPI_S_WR |-> !mem_data_bus_oe_o)
        else $error("data bus driven outside a write");
    chk_ecc_release: assert property (mem_check_bits_oe_o == mem_data_bus_oe_o)
        else $error("check bits not driven with data");
    chk_x4_strobe: assert property (mem_data_bus_oe_o && x4_reg |-> mem_mask_o == mem_strobe_o)
        else $error("mask pins not following strobes on x4");
    chk_rmw_full: assert property (mem_data_bus_oe_o && x4_reg |-> &hold_reg.byte_en)
        else $error("x4 write with bytes disabled");

endmodule : ddrpi_pin_if

// >>> testbench/ddrpi_dimm_model.sv
// Behavioural DIMM on the data, check-bit and strobe pins.
// Assumes the bench enables it while a read is outstanding.
`timescale 1ns/10ps
module ddrpi_dimm_model (
    input  wire logic        link_clk_i,
    input  wire logic        en_i,
    input  wire logic [63:0] d_i,
    input  wire logic [7:0]  e_i,
    output logic      [63:0] dq_o,
    output logic      [7:0]  ecc_o,
    output logic      [8:0]  dqs_o,
    output logic      [8:0]  dm_o
);
    // Released data and check-bit lines show the inverse so a stale value never matches.
    assign dq_o  = en_i ? d_i : ~d_i;
    assign ecc_o = en_i ? e_i : ~e_i;
    assign dqs_o = en_i ? {9{link_clk_i}} : 9'h000;
    assign dm_o  = en_i ? {9{link_clk_i}} : 9'h000;
endmodule : ddrpi_dimm_model

// >>> testbench/tb_top.sv
// Self-checking bench of the pin interface with a DIMM model.
// Assumes the design asserts its own timing rules internally.
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 0, resetn_i = 0, lck = 0, ini = 0, sr = 0, vld = 0, men = 0, x4 = 0;
    ddrpi_pkg::ddrpi_req_s req = '0;
    ddrpi_pkg::ddrpi_rd_s rd;
    logic rdy, rv, tmo, ca, cb, doe, eoe, soe, moe;
    logic [14:0] pa, pb;
    logic [63:0] dpo, dmo;
    logic [7:0] epo, emo;
    logic [8:0] spo, smo, mpo, mmo;
    int miscompares = 0, n_compared = 0;
    always #2.5 clk_i = ~clk_i;
    always #32 lck = ~lck;
    ddrpi_dimm_model u_mem (.link_clk_i(lck), .en_i(men), .d_i(64'h0123456789ABCDEF), .e_i(8'h5A),
        .dq_o(dmo), .ecc_o(emo), .dqs_o(smo), .dm_o(mmo));
    ddrpi_pin_if u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .init_phase_i(ini), .self_refresh_i(sr),
        .x4_mode_i(x4), .req_valid_i(vld), .req_i(req), .req_ready_o(rdy), .rd_valid_o(rv), .rd_o(rd),
        .rd_timeout_o(tmo), .forwarded_mem_clock_i(lck), .mem_addr_primary_o(pa),
        .mem_addr_inverted_copy_o(pb), .mem_clock_enable_a_o(ca), .mem_clock_enable_b_o(cb),
        .mem_data_bus_i(doe ? dpo : dmo), .mem_data_bus_o(dpo), .mem_data_bus_oe_o(doe),
        .mem_check_bits_i(eoe ? epo : emo), .mem_check_bits_o(epo), .mem_check_bits_oe_o(eoe),
        .mem_strobe_i(soe ? spo : smo), .mem_strobe_o(spo), .mem_strobe_oe_o(soe),
        .mem_mask_i(moe ? mpo : mmo), .mem_mask_o(mpo), .mem_mask_oe_o(moe));
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [71:0] g, input logic [71:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    // Bounded wait for a design flag; a hang ends the run.
    task automatic wait_on(ref logic f);
        int n;
        for (n = 0; n < 2000 && f !== 1'b1; n++) @(negedge clk_i);
        if (n == 2000) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_on
    task automatic send(input logic wr, input logic [14:0] c, input logic [8:0] be);
        wait_on(rdy);
        req.op = wr ? ddrpi_pkg::DDRPI_OP_WRITE : ddrpi_pkg::DDRPI_OP_READ;
        req.row = 15'h1234; req.col = c; req.wdata = 64'hA5A5F00D0BADCAFE; req.wecc = 8'hC3; req.byte_en = be;
        vld = 1;
        @(negedge clk_i);
        vld = 0;
    endtask : send
    // An x4 partial write reads the line from the model first, so the model is enabled for it.
    task automatic t_write(input logic init, input logic x4m, input logic [8:0] be, input logic [63:0] wd);
        ini = init;
        x4 = x4m;
        men = x4m;
        send(1, 15'h0155, be);
        wait_on(doe);
        cmp({dpo, epo}, {wd, 8'hC3});
        cmp({eoe, pa}, {1'b1, 15'h0155});
        cmp(pb, init ? 15'h0155 : 15'h7AAA);
        cmp({soe, moe, spo, mpo}, {2'b11, 9'h000, x4m ? 9'h000 : ~be});
        repeat (8) @(negedge clk_i);
        cmp({doe, spo, mpo}, {1'b1, 9'h1FF, x4m ? 9'h1FF : ~be});
        wait_on(rdy);
        cmp({doe, eoe, soe, moe}, 4'b0000);
        ini = 0;
        x4 = 0;
        men = 0;
        $display("write test done");
    endtask : t_write
    task automatic t_read(input logic x4m);
        x4 = x4m;
        men = 1;
        send(0, 15'h0402, 9'h1FF);
        wait_on(rv);
        cmp(rd, {64'h0123456789ABCDEF, 8'h5A});
        cmp({doe, eoe, soe, moe}, 4'b0000);
        men = 0;
        x4 = 0;
        $display("read test done");
    endtask : t_read
    // With the model silent no strobe arrives, so the read must give up, not hang.
    task automatic t_timeout;
        send(0, 15'h0402, 9'h1FF);
        wait_on(tmo);
        cmp({tmo, rv}, 2'b10);
        wait_on(rdy);
        $display("timeout test done");
    endtask : t_timeout
    task automatic t_cke;
        cmp({ca, cb, doe, eoe}, 4'b0000);
        resetn_i = 1;
        repeat (60) @(negedge clk_i);
        cmp({ca, cb}, 2'b11);
        sr = 1;
        repeat (60) @(negedge clk_i);
        cmp({ca, cb}, 2'b00);
        sr = 0;
        repeat (60) @(negedge clk_i);
        cmp({ca, cb}, 2'b11);
        $display("clock enable test done");
    endtask : t_cke
    initial begin
        repeat (6) @(negedge clk_i);
        t_cke();
        t_write(0, 0, 9'h1FF, 64'hA5A5F00D0BADCAFE);
        t_write(1, 0, 9'h0F0, 64'hA5A5F00D0BADCAFE);
        t_write(0, 1, 9'h10F, 64'h012345670BADCAFE);
        t_read(0);
        t_read(1);
        t_timeout();
        give_verdict();
    end
endmodule : tb_top
